//--- shared/latc_map.svh
// register map, field positions, reset values and sizes of the trigger/capture controller
`ifndef LATC_MAP_SVH
`define LATC_MAP_SVH

// fixed sizes
`define LATC_DW 32
`define LATC_AW 10
`define LATC_NCMP 8
`define LATC_NWIN 8

// register word addresses
`define LATC_A_CTRL 5'h00
`define LATC_A_TCFG 5'h01
`define LATC_A_CCFG 5'h02
`define LATC_A_WCFG 5'h03
`define LATC_A_STAT 5'h04
`define LATC_A_ISTAT 5'h05
`define LATC_A_IMASK 5'h06
`define LATC_A_RDPTR 5'h07
`define LATC_A_BUFDAT 5'h08
`define LATC_A_MARK0 5'h10

// field positions
`define LATC_F_ARM 0
`define LATC_F_STOP 1
`define LATC_F_TMODE 0
`define LATC_F_OMODE 4
`define LATC_F_CMODE 8
`define LATC_F_TMASK 0
`define LATC_F_TAND 8
`define LATC_F_CMASK 16
`define LATC_F_CAND 24
`define LATC_F_DLOG 0
`define LATC_F_NLOG 4
`define LATC_F_TPOS 16
`define LATC_F_STATE 0
`define LATC_F_WIN 4
`define LATC_F_DONE 8
`define LATC_I_TRIG 0
`define LATC_I_WDONE 1
`define LATC_I_FULL 2

// reset values
`define LATC_R_TMODE 3'h0
`define LATC_R_OMODE 2'h0
`define LATC_R_CMODE 1'h0
`define LATC_R_MASK 8'h00
`define LATC_R_DLOG 4'ha
`define LATC_R_NLOG 2'h0
`define LATC_R_TPOS 10'h000
`define LATC_R_IMASK 3'h0

`endif

//--- shared/latc_pkg.sv
// types of the trigger/capture controller
package latc_pkg;
    typedef enum logic [2:0] {LATC_IDLE, LATC_PRE, LATC_WAIT, LATC_POST, LATC_FULL} latc_state_t;
    typedef enum logic [2:0] {
        basic_only_mode,
        state_machine_only_mode,
        basic_or_external_trigger_mode,
        state_machine_or_external_trigger_mode,
        external_only_mode
    } latc_tmode_t;
    typedef enum logic [1:0] {
        output_disabled_mode,
        internal_only_mode,
        pass_through_mode,
        combined_output_mode
    } latc_omode_t;
    typedef enum logic {capture_always_mode, capture_conditional_mode} latc_cmode_t;
endpackage

//--- hdl/latc_core.sv
// trigger and capture controller of an embedded logic analyzer
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "latc_map.svh"

module latc_core
    import latc_pkg::*;
#(
    parameter bit EXT_IN_EN = 1'b1,
    parameter bit EXT_OUT_EN = 1'b1
)
(
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic [`LATC_DW-1:0] probe_data_in,
    input wire logic [`LATC_NCMP-1:0] cmp_hit_in,
    input wire logic sm_trigger_in,
    input wire logic external_trigger_input_in,
    output logic external_trigger_input_acknowledge_out,
    output logic external_trigger_output_out,
    input wire logic external_trigger_output_acknowledge_in,
    output logic irq_out
);

    latc_state_t state_ff;
    latc_state_t nxt_state;
    latc_tmode_t tmode_ff;
    latc_omode_t omode_ff;
    latc_cmode_t cmode_ff;
    logic [7:0] tmask_ff;
    logic [7:0] cmask_ff;
    logic tand_ff;
    logic cand_ff;
    logic [3:0] dlog_ff;
    logic [1:0] nlog_ff;
    logic [9:0] tpos_ff;
    logic [2:0] imask_ff;
    logic [2:0] istat_ff;
    logic [9:0] samp_ff;
    logic [9:0] nxt_samp;
    logic [2:0] win_ff;
    logic [2:0] nxt_win;
    logic [3:0] done_ff;
    logic [9:0] rdptr_ff;
    logic [31:0] rdata_ff;
    logic [9:0] mark_ff [`LATC_NWIN];
    logic [`LATC_DW-1:0] mem [1 << `LATC_AW];
    logic ext_d_ff;
    logic in_ack_ff;
    logic out_ff;
    logic [3:0] max_dlog;
    logic [3:0] eff_dlog;
    logic [9:0] win_last;
    logic [9:0] tpos_eff;
    logic [2:0] nwin_last;
    logic [9:0] wa;
    logic ext_in;
    logic ext_rise;
    logic basic_hit;
    logic cap_qual;
    logic int_trig;
    logic fire;
    logic out_src;
    logic capturing;
    logic store;
    logic trig_ev;
    logic win_done;
    logic arm_cmd;
    logic stop_cmd;
    logic wr_ok;
    logic rd_ok;
    logic [2:0] ev;

    assign wr_ok = ce_in && reg_wr_in;
    assign rd_ok = ce_in && reg_rd_in;
    assign arm_cmd = wr_ok && reg_addr_in == `LATC_A_CTRL && reg_wdata_in[`LATC_F_ARM];
    assign stop_cmd = wr_ok && reg_addr_in == `LATC_A_CTRL && reg_wdata_in[`LATC_F_STOP];

    // window geometry: depth is clipped so that all windows fit the buffer
    assign max_dlog = 4'(`LATC_AW) - {2'h0, nlog_ff};
    assign eff_dlog = (dlog_ff > max_dlog) ? max_dlog : dlog_ff;
    assign win_last = 10'((11'h1 << eff_dlog) - 11'h1);
    assign tpos_eff = tpos_ff & win_last;
    assign nwin_last = 3'((4'h1 << nlog_ff) - 4'h1);
    assign wa = 10'((11'(win_ff) << eff_dlog) | 11'(samp_ff));

    // unconfigured external ports read as idle so no mode can see them
    assign ext_in = EXT_IN_EN && external_trigger_input_in;
    assign ext_rise = ext_in && !ext_d_ff;

    // comparator combination: and-of-selected or or-of-selected
    assign basic_hit = tand_ff ? &(cmp_hit_in | ~tmask_ff) : |(cmp_hit_in & tmask_ff);
    assign cap_qual = cand_ff ? &(cmp_hit_in | ~cmask_ff) : |(cmp_hit_in & cmask_ff);
    assign int_trig = (tmode_ff == state_machine_only_mode ||
                       tmode_ff == state_machine_or_external_trigger_mode) ?
                      sm_trigger_in : basic_hit;

    // trigger decision by mode
    always_comb
    begin
        case (tmode_ff)
        basic_only_mode: fire = basic_hit;
        state_machine_only_mode: fire = sm_trigger_in;
        basic_or_external_trigger_mode: fire = basic_hit || ext_in;
        state_machine_or_external_trigger_mode: fire = sm_trigger_in || ext_in;
        external_only_mode: fire = ext_rise;
        default: fire = 1'h0;
        endcase
    end

    // what reaches the external trigger output
    always_comb
    begin
        case (omode_ff)
        output_disabled_mode: out_src = 1'h0;
        internal_only_mode: out_src = int_trig;
        pass_through_mode: out_src = ext_in;
        combined_output_mode: out_src = int_trig || ext_in;
        default: out_src = 1'h0;
        endcase
    end

    assign capturing = state_ff == LATC_PRE || state_ff == LATC_WAIT || state_ff == LATC_POST;
    assign store = capturing && (cmode_ff == capture_always_mode || cap_qual);

    // sequencing of windows; waiting overwrites the trigger slot until the trigger comes
    always_comb
    begin
        nxt_state = state_ff;
        nxt_samp = samp_ff;
        nxt_win = win_ff;
        trig_ev = 1'h0;
        win_done = 1'h0;
        case (state_ff)
        LATC_IDLE, LATC_FULL:
        begin
            if (arm_cmd)
            begin
                nxt_samp = 10'h0;
                nxt_win = 3'h0;
                nxt_state = (tpos_eff == 10'h0) ? LATC_WAIT : LATC_PRE;
            end
        end
        LATC_PRE:
        begin
            // triggers are not looked at here, so they can be missed
            if (store)
            begin
                nxt_samp = 10'(samp_ff + 10'h1);
                if (samp_ff == 10'(tpos_eff - 10'h1))
                    nxt_state = LATC_WAIT;
            end
        end
        LATC_WAIT:
        begin
            if (fire)
            begin
                trig_ev = 1'h1;
                nxt_state = LATC_POST;
                if (store && samp_ff == win_last)
                    win_done = 1'h1;
                else if (store)
                    nxt_samp = 10'(samp_ff + 10'h1);
            end
        end
        LATC_POST:
        begin
            if (store && samp_ff == win_last)
                win_done = 1'h1;
            else if (store)
                nxt_samp = 10'(samp_ff + 10'h1);
        end
        default: nxt_state = LATC_IDLE;
        endcase
        if (win_done)
        begin
            nxt_samp = 10'h0;
            if (win_ff == nwin_last)
                nxt_state = LATC_FULL;
            else
            begin
                nxt_win = 3'(win_ff + 3'h1);
                nxt_state = (tpos_eff == 10'h0) ? LATC_WAIT : LATC_PRE;
            end
        end
        if (stop_cmd && state_ff != LATC_IDLE)
            nxt_state = LATC_IDLE;
    end

    // state register
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
            state_ff <= LATC_IDLE;
        else if (ce_in)
            state_ff <= nxt_state;
    end

    // sample and window counters
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            samp_ff <= 10'h0;
            win_ff <= 3'h0;
        end
        else if (ce_in)
        begin
            samp_ff <= nxt_samp;
            win_ff <= nxt_win;
        end
    end

    // count of completely filled windows, kept across a stop for the upload
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
            done_ff <= 4'h0;
        else if (arm_cmd && (state_ff == LATC_IDLE || state_ff == LATC_FULL))
            done_ff <= 4'h0;
        else if (ce_in && win_done)
            done_ff <= 4'(done_ff + 4'h1);
    end

    // sample buffer; no reset, contents are only valid up to the filled windows
    always_ff @(posedge clock_in)
    begin
        if (ce_in && store)
            mem[wa] <= probe_data_in;
    end

    // one trigger mark per window
    generate
        for (genvar i = 0; i < `LATC_NWIN; i++)
        begin : g_mark
            always_ff @(posedge clock_in)
            begin
                if (!rstn_in)
                    mark_ff[i] <= 10'h0;
                else if (ce_in && trig_ev && win_ff == 3'(i))
                    mark_ff[i] <= wa;
            end
        end
    endgenerate

    // configuration registers written by software
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            tmode_ff <= latc_tmode_t'(`LATC_R_TMODE);
            omode_ff <= latc_omode_t'(`LATC_R_OMODE);
            cmode_ff <= latc_cmode_t'(`LATC_R_CMODE);
            tmask_ff <= `LATC_R_MASK;
            cmask_ff <= `LATC_R_MASK;
            tand_ff <= 1'h0;
            cand_ff <= 1'h0;
            dlog_ff <= `LATC_R_DLOG;
            nlog_ff <= `LATC_R_NLOG;
            tpos_ff <= `LATC_R_TPOS;
            imask_ff <= `LATC_R_IMASK;
        end
        else if (wr_ok)
        begin
            case (reg_addr_in)
            `LATC_A_TCFG:
            begin
                tmode_ff <= latc_tmode_t'(reg_wdata_in[`LATC_F_TMODE+:3]);
                omode_ff <= latc_omode_t'(reg_wdata_in[`LATC_F_OMODE+:2]);
                cmode_ff <= latc_cmode_t'(reg_wdata_in[`LATC_F_CMODE]);
            end
            `LATC_A_CCFG:
            begin
                tmask_ff <= reg_wdata_in[`LATC_F_TMASK+:8];
                tand_ff <= reg_wdata_in[`LATC_F_TAND];
                cmask_ff <= reg_wdata_in[`LATC_F_CMASK+:8];
                cand_ff <= reg_wdata_in[`LATC_F_CAND];
            end
            `LATC_A_WCFG:
            begin
                dlog_ff <= reg_wdata_in[`LATC_F_DLOG+:4];
                nlog_ff <= reg_wdata_in[`LATC_F_NLOG+:2];
                tpos_ff <= reg_wdata_in[`LATC_F_TPOS+:10];
            end
            `LATC_A_IMASK: imask_ff <= reg_wdata_in[2:0];
            default: ;
            endcase
        end
    end

    // upload pointer, auto-incremented by each buffer data read
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
            rdptr_ff <= 10'h0;
        else if (wr_ok && reg_addr_in == `LATC_A_RDPTR)
            rdptr_ff <= reg_wdata_in[9:0];
        else if (rd_ok && reg_addr_in == `LATC_A_BUFDAT)
            rdptr_ff <= 10'(rdptr_ff + 10'h1);
    end

    // sticky events; a new event beats the clearing read in the same cycle
    assign ev[`LATC_I_TRIG] = trig_ev;
    assign ev[`LATC_I_WDONE] = win_done;
    assign ev[`LATC_I_FULL] = win_done && win_ff == nwin_last;

    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
            istat_ff <= 3'h0;
        else if (ce_in)
        begin
            if (rd_ok && reg_addr_in == `LATC_A_ISTAT)
                istat_ff <= ev;
            else
                istat_ff <= istat_ff | ev;
        end
    end

    assign irq_out = |(istat_ff & imask_ff);

    // read data, valid in the cycle after the read strobe
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
            rdata_ff <= 32'h0;
        else if (rd_ok)
        begin
            if (reg_addr_in[4])
                rdata_ff <= {22'h0, mark_ff[reg_addr_in[2:0]]};
            else
            begin
                case (reg_addr_in)
                `LATC_A_TCFG:
                    rdata_ff <= {23'h0, cmode_ff, 2'h0, omode_ff, 1'h0, tmode_ff};
                `LATC_A_CCFG:
                    rdata_ff <= {7'h0, cand_ff, cmask_ff, 7'h0, tand_ff, tmask_ff};
                `LATC_A_WCFG: rdata_ff <= {6'h0, tpos_ff, 10'h0, nlog_ff, dlog_ff};
                `LATC_A_STAT:
                    rdata_ff <= {20'h0, done_ff, 1'h0, win_ff, 1'h0, 3'(state_ff)};
                `LATC_A_ISTAT: rdata_ff <= {29'h0, istat_ff};
                `LATC_A_IMASK: rdata_ff <= {29'h0, imask_ff};
                `LATC_A_RDPTR: rdata_ff <= {22'h0, rdptr_ff};
                `LATC_A_BUFDAT: rdata_ff <= mem[rdptr_ff];
                default: rdata_ff <= 32'h0;
                endcase
            end
        end
        else if (ce_in)
            rdata_ff <= 32'h0; // frozen with the rest of the state while disabled
    end

    assign reg_rdata_out = rdata_ff;

    // external trigger handshakes; the output holds until the receiver acknowledges
    always_ff @(posedge clock_in)
    begin
        if (!rstn_in)
        begin
            ext_d_ff <= 1'h0;
            in_ack_ff <= 1'h0;
            out_ff <= 1'h0;
        end
        else if (ce_in)
        begin
            ext_d_ff <= ext_in;
            in_ack_ff <= ext_rise;
            out_ff <= EXT_OUT_EN && omode_ff != output_disabled_mode &&
                      (out_src || (out_ff && !external_trigger_output_acknowledge_in));
        end
    end

    assign external_trigger_input_acknowledge_out = in_ack_ff;
    assign external_trigger_output_out = out_ff;

    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    out_disabled_a: assert property (
        ce_in && omode_ff == output_disabled_mode |=> !external_trigger_output_out)
        else $error("trigger output active while disabled");
    pass_through_a: assert property (
        ce_in && EXT_OUT_EN && omode_ff == pass_through_mode && ext_in
        |=> external_trigger_output_out)
        else $error("external input not passed to output");
    internal_out_a: assert property (
        ce_in && EXT_OUT_EN && omode_ff == internal_only_mode && int_trig
        |=> external_trigger_output_out)
        else $error("internal trigger not driven out");
    combined_out_a: assert property (
        ce_in && EXT_OUT_EN && omode_ff == combined_output_mode && (int_trig || ext_in)
        |=> external_trigger_output_out)
        else $error("combined output missing");
    no_store_idle_a: assert property (
        state_ff == LATC_IDLE || state_ff == LATC_FULL |-> !store)
        else $error("sample stored outside capture");
    always_store_a: assert property (
        ce_in && state_ff == LATC_POST && cmode_ff == capture_always_mode && !stop_cmd
        && samp_ff != win_last |=> samp_ff == $past(samp_ff) + 10'h1)
        else $error("always mode skipped a sample");
    cond_hold_a: assert property (
        ce_in && state_ff == LATC_POST && cmode_ff == capture_conditional_mode && !cap_qual
        |=> samp_ff == $past(samp_ff))
        else $error("unqualified sample stored");
    combo_fire_a: assert property (
        state_ff == LATC_WAIT && tmode_ff == basic_or_external_trigger_mode
        && (ext_in || basic_hit) |-> trig_ev)
        else $error("combined trigger did not fire");
    edge_only_a: assert property (
        ce_in && state_ff == LATC_WAIT && tmode_ff == external_only_mode && !ext_rise
        && !stop_cmd |=> state_ff == LATC_WAIT)
        else $error("trigger without rising edge");
    pre_blind_a: assert property (
        state_ff == LATC_PRE |-> !trig_ev)
        else $error("trigger evaluated in pre-trigger");
    pre_to_wait_a: assert property (
        ce_in && state_ff == LATC_PRE && store && !stop_cmd
        && samp_ff == 10'(tpos_eff - 10'h1) |=> state_ff == LATC_WAIT)
        else $error("pre-trigger fill did not end at position");
    arm_entry_a: assert property (
        state_ff == LATC_IDLE && arm_cmd && !stop_cmd
        |=> state_ff == (($past(tpos_eff) == 10'h0) ? LATC_WAIT : LATC_PRE))
        else $error("wrong state after arm");
    rearm_a: assert property (
        ce_in && win_done && win_ff != nwin_last && tpos_eff == 10'h0 && !stop_cmd
        |=> state_ff == LATC_WAIT && samp_ff == 10'h0)
        else $error("next window not ready to trigger");
    full_last_a: assert property (
        ce_in && win_done && win_ff == nwin_last && !stop_cmd |=> state_ff == LATC_FULL)
        else $error("buffer not full after last window");
    stop_halt_a: assert property (
        stop_cmd && capturing |=> state_ff == LATC_IDLE && !store)
        else $error("stop did not halt capture");
    mark_set_a: assert property (
        ce_in && trig_ev |=> mark_ff[$past(win_ff)] == $past(wa))
        else $error("trigger mark not recorded");
    ack_pulse_a: assert property (
        ce_in && ext_rise |=> external_trigger_input_acknowledge_out
        ##1 !external_trigger_input_acknowledge_out)
        else $error("acknowledge not a single pulse");
    geometry_a: assert property (
        (11'(win_last) + 11'h1) * (11'(nwin_last) + 11'h1) <= 11'h400)
        else $error("windows exceed buffer");

    full_seen_c: cover property (ce_in && win_done && win_ff == nwin_last);
    rearm_seen_c: cover property (win_done && win_ff != nwin_last ##1 state_ff == LATC_PRE);
    stop_seen_c: cover property (stop_cmd && state_ff == LATC_POST && done_ff != 4'h0);
endmodule

//--- verification/latc_partner.sv
// far-side model: cross-trigger source and trigger receiver
`timescale 1ns/1ps
module latc_partner
(
    input wire logic clock_in,
    input wire logic fire_in,
    output logic external_trigger_output,
    input wire logic trig_ack_in,
    input wire logic out_in,
    output logic out_ack_out,
    output logic seen_out,
    input wire logic clr_in
);
    // both far-side lines start low, as a quiet neighbour would
    initial
    begin
        external_trigger_output = 1'b0;
        out_ack_out = 1'b0;
        seen_out = 1'b0;
    end
    // source keeps its pulse up until acknowledged, so no event is dropped
    always @(posedge clock_in)
    begin
        external_trigger_output <= fire_in | (external_trigger_output & ~trig_ack_in);
        out_ack_out <= out_in & ~out_ack_out; // one-cycle answer per pulse
        seen_out <= ~clr_in & (seen_out | out_in);
    end
endmodule

//--- verification/latc_core_tb_top.sv
// self-checking bench of the trigger/capture controller
`timescale 1ns/1ps
`include "latc_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module latc_core_tb_top;
    logic clk = 1'b0, rstn = 1'b0, wr_s = 1'b0, rd_s = 1'b0, sm = 1'b0;
    logic fire = 1'b0, clr = 1'b0, ce = 1'b1;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0, cnt = 32'h0, rdata, d, tv;
    logic [7:0] hit = 8'h00;
    wire logic ack_in, external_trigger_output, out_ack, ext_in, seen, irq;
    int err_count = 0, tests_run = 0, acks = 0, fires = 0;
    logic [31:0] q[$];

    latc_core latc_core_inst (.clock_in(clk), .rstn_in(rstn), .ce_in(ce),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
        .reg_rdata_out(rdata), .probe_data_in(cnt), .cmp_hit_in(hit), .sm_trigger_in(sm),
        .external_trigger_input_in(ext_in), .external_trigger_input_acknowledge_out(ack_in),
        .external_trigger_output_out(external_trigger_output),
        .external_trigger_output_acknowledge_in(out_ack), .irq_out(irq));
    latc_partner latc_partner_inst (.clock_in(clk), .fire_in(fire), .external_trigger_output(ext_in),
        .trig_ack_in(ack_in), .out_in(external_trigger_output), .out_ack_out(out_ack), .seen_out(seen),
        .clr_in(clr));

    initial
    forever #2.5 clk = ~clk;
    // probe is a counter; comparator bit 0 marks odd samples, the rest is noise
    always @(posedge clk)
    begin
        cnt <= cnt + 1;
        hit <= {7'($urandom), ~cnt[0]};
    end
    // sampled mid-cycle, clear of the edge
    always @(negedge clk)
    begin
        acks += int'(ack_in);
        if (sm)
            tv = cnt;
    end

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [4:0] a);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic wait_st(input logic [2:0] s);
        int i;
        i = 0;
        do
        begin
            rd(`LATC_A_STAT);
            i++;
        end
        while (d[2:0] !== s && i < 60);
        `CHK(d[2:0], s)
        if (d[2:0] !== s)
            report_and_stop();
    endtask
    task automatic arm(input logic [31:0] w, input logic [31:0] t);
        wr(`LATC_A_WCFG, w);
        wr(`LATC_A_TCFG, t);
        rd(`LATC_A_ISTAT);
        wr(`LATC_A_CTRL, 32'h1);
    endtask
    task automatic rbuf(input logic [31:0] p, input int n);
        q.delete();
        wr(`LATC_A_RDPTR, p);
        repeat (n)
        begin
            rd(`LATC_A_BUFDAT);
            q.push_back(d);
        end
    endtask
    task automatic pulse();
        sm <= 1'b1;
        @(posedge clk);
        sm <= 1'b0;
    endtask

    initial
    begin
        void'($urandom(12294));
        cnt <= $urandom;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(`LATC_A_WCFG);
        `CHK(d, 32'ha)
        rd(5'h1f);
        `CHK(d, 32'h0)
        // every output mode against the internal and the external source
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 2; s++)
            begin
                wr(`LATC_A_TCFG, 32'(1 | (m << 4)));
                clr <= 1'b1;
                @(posedge clk);
                clr <= 1'b0;
                sm <= (s == 0);
                fire <= (s == 1);
                fires += s;
                @(posedge clk);
                sm <= 1'b0;
                fire <= 1'b0;
                repeat (6) @(posedge clk);
                `CHK(seen, 1'((m == 3) || (m == 1 && s == 0) || (m == 2 && s == 1)))
            end
        // one window of 4, position 0, always mode
        arm(32'h2, 32'h1);
        rd(`LATC_A_STAT);
        `CHK(d[2:0], 3'h2)
        pulse();
        wait_st(3'h4);
        rd(`LATC_A_MARK0);
        `CHK(d, 32'h0)
        rbuf(32'h0, 4);
        foreach (q[i])
            `CHK(q[i], tv + 32'(i))
        `CHK(irq, 1'b0)
        wr(`LATC_A_IMASK, 32'h7);
        `CHK(irq, 1'b1)
        rd(`LATC_A_ISTAT);
        `CHK(d, 32'h7)
        `CHK(irq, 1'b0)
        // a strobe while the clock enable is low must leave the mask alone
        ce <= 1'b0;
        wr(`LATC_A_IMASK, 32'h0);
        ce <= 1'b1;
        rd(`LATC_A_IMASK);
        `CHK(d, 32'h7)
        // conditional mode keeps only odd samples
        wr(`LATC_A_CCFG, 32'h0001_0000);
        arm(32'h2, 32'h101);
        pulse();
        wait_st(3'h4);
        rbuf(32'h0, 4);
        `CHK(q[1][0], 1'b1)
        for (int i = 1; i < 4; i++)
            `CHK(q[i], q[1] + 32'(2 * (i - 1)))
        // two windows back to back, position 0
        arm(32'h12, 32'h1);
        sm <= 1'b1;
        wait_st(3'h4);
        sm <= 1'b0;
        rd(`LATC_A_MARK0 + 5'h1);
        `CHK(d, 32'h4)
        rbuf(32'h0, 8);
        foreach (q[i])
            `CHK(q[i], q[0] + 32'(i))
        // two windows, position 3: triggers ignored during pre-fill
        arm(32'h0003_0012, 32'h1);
        rd(`LATC_A_STAT);
        `CHK(d[2:0], 3'h1)
        sm <= 1'b1;
        wait_st(3'h4);
        sm <= 1'b0;
        `CHK(d[11:8], 4'h2)
        rd(`LATC_A_MARK0 + 5'h1);
        `CHK(d, 32'h7)
        // stop after the first of two windows
        arm(32'h12, 32'h1);
        pulse();
        repeat (10) @(posedge clk);
        wr(`LATC_A_CTRL, 32'h2);
        rd(`LATC_A_STAT);
        `CHK({d[11:8], d[2:0]}, 7'h08)
        // external trigger in each mode that listens to it, plus basic-only on odd samples
        wr(`LATC_A_CCFG, 32'h0001_0101);
        for (int t = 0; t < 5; t++)
        begin
            if (t == 1)
                continue;
            arm(32'h2, 32'(t));
            fire <= 1'b1;
            fires++;
            @(posedge clk);
            fire <= 1'b0;
            wait_st(3'h4);
        end
        `CHK(acks, fires)
        report_and_stop();
    end
endmodule
